// File: logic/hm_pkg.sv
// Shared constants, register map and types of the homing sequencer
package hm_pkg;
  // Clock and motion time base
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYC       = (TICK_PERIOD_NS + CLK_PERIOD_NS
                                            - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 7;
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_METHOD   = 8'h08;
  localparam logic [7:0] A_HSPEED   = 8'h0C;
  localparam logic [7:0] A_CSPEED   = 8'h10;
  localparam logic [7:0] A_SHIFT    = 8'h14;
  localparam logic [7:0] A_ACCEL    = 8'h18;
  localparam logic [7:0] A_HOMEDATA = 8'h1C;
  localparam logic [7:0] A_AFTERDOG = 8'h20;
  localparam logic [7:0] A_FILTER   = 8'h24;
  localparam logic [7:0] A_POSITION = 8'h28;
  localparam logic [7:0] A_INPUTS   = 8'h2C;
  // Field positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_ABORT = 1;
  localparam int unsigned MC_DIR     = 4;
  localparam int unsigned MC_POL     = 8;
  localparam logic [3:0]  METHOD_COUNT  = 4'h6;
  localparam logic [3:0]  METHOD_CRADLE = 4'h7;
  // Filtered input vector layout
  localparam int unsigned IN_DOG  = 0;
  localparam int unsigned IN_AUTO = 1;
  localparam int unsigned IN_TS0  = 2;
  localparam int unsigned IN_PROG = 5;
  localparam int unsigned IN_W    = 6;
  // Reset values
  localparam logic [15:0] RST_METHOD = 16'h0106;
  localparam logic [15:0] RST_HSPEED = 16'h0064;
  localparam logic [15:0] RST_CSPEED = 16'h000A;
  localparam logic [15:0] RST_ACCEL  = 16'h0000;
  localparam logic [7:0]  RST_FILTER = 8'h02;
  // Sequencer states
  typedef enum logic [2:0] {
    HM_IDLE, HM_FAST, HM_COUNT, HM_ZWAIT, HM_SHIFT, HM_STOP, HM_LOAD, HM_DONE
  } hm_state_t;
  // Distance moved from a marked point in the travel direction
  function automatic logic [31:0] hm_dist(input logic [31:0] pos,
                                          input logic [31:0] mark,
                                          input logic        dir);
    hm_dist = dir ? (pos - mark) : (mark - pos);
  endfunction : hm_dist
endpackage : hm_pkg

// File: logic/hm_in_filter.sv
// Input filter that delays every input change by a programmable time
`timescale 1ns/10ps
`default_nettype none
module hm_in_filter #(
  parameter int unsigned W  = 6,
  parameter int unsigned FW = 8
) (
  // Clock, reset and time base
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          tick,
  // Filter time in ticks
  input  wire logic [FW-1:0] ftime,
  // Raw and filtered inputs
  input  wire logic [W-1:0]  raw,
  output logic      [W-1:0]  stable_q
);
  logic [FW-1:0] cnt_q [W];

  if (W < 1 || FW < 1) begin : g_chk
    $error("hm_in_filter: widths must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // A change must persist for ftime+1 ticks; a glitch restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= '0;
      for (int i = 0; i < W; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < W; i++) begin
        if (raw[i] == stable_q[i]) begin
          cnt_q[i] <= '0;
        end else if (tick) begin
          if (cnt_q[i] >= ftime) begin
            stable_q[i] <= raw[i];
          end else begin
            cnt_q[i] <= cnt_q[i] + FW'(1);
          end
        end
      end
    end
  end

  flt_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(stable_q[0]) |->
      $past(tick) && $past(cnt_q[0]) >= $past(ftime))
    else $error("filtered input changed before its filter time");
endmodule : hm_in_filter
`default_nettype wire

// File: logic/hm_ramp.sv
// Speed ramp with a programmable acceleration/deceleration time constant
`timescale 1ns/10ps
`default_nettype none
module hm_ramp #(
  parameter int unsigned SW = 16
) (
  // Clock, reset and time base
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          tick,
  // Target speed and ticks per speed step, less one
  input  wire logic [SW-1:0] target,
  input  wire logic [15:0]   accel_ticks,
  // Present speed
  output logic      [SW-1:0] speed_q
);
  logic [15:0] cnt_q;

  if (SW < 2) begin : g_chk
    $error("hm_ramp: speed width too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // homing ramp rate
  // One unit of speed per accel_ticks+1 ticks, in both directions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_q <= '0;
      cnt_q   <= 16'h0000;
    end else if (tick) begin
      if (cnt_q >= accel_ticks) begin
        cnt_q <= 16'h0000;
        if (speed_q < target) begin
          speed_q <= speed_q + SW'(1);
        end else if (speed_q > target) begin
          speed_q <= speed_q - SW'(1);
        end
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  ramp_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(speed_q) |-> $past(tick) &&
      (speed_q - $past(speed_q) == SW'(1) ||
       $past(speed_q) - speed_q == SW'(1)))
    else $error("speed moved by more than one step or off tick");
endmodule : hm_ramp
`default_nettype wire

// File: logic/hm_dog_homing_seq.sv
// Dog referenced homing sequencer with APB register slave
// Contract
// - Method digit 6 selects count-type dog front end homing.
// - Count type: decelerate at dog, home after travel plus shift.
// - Count type never uses the encoder index pulse.
// - Count-type home depends on dog sampling; error grows with speed.
// - Count-type home may shift when homing speed changes.
// - Count-type travel is measured from the dog front end.
// - Method digit 7 selects dog cradle homing.
// - Cradle: first index pulse after dog front end is reference.
// - Cradle: home is index position offset by the shift distance.
// - Homing speed until dog detected, creep speed afterwards.
// - Direction and dog polarity come from the method configuration.
// - All homing motion uses the homing acceleration time constant.
// - On completion the position is loaded with home data.
// - Every external input change is delayed by the filter time; index_pulse is used unfiltered here.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module hm_dog_homing_seq #(
  parameter int unsigned TICK_CYC = hm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Input devices
  input  wire logic        auto_manual_select,
  input  wire logic        table_select_bit0,
  input  wire logic        table_select_bit1,
  input  wire logic        table_select_bit2,
  input  wire logic        homing_program_command,
  input  wire logic        dog_in,
  input  wire logic        index_pulse,
  // Motion command and status
  output logic [15:0]      speed_cmd,
  output logic             move_dir,
  output logic             homing_busy,
  output logic             homing_done,
  output logic             home_error
);
  logic [15:0] homing_method_config;
  logic [15:0] homing_speed;
  logic [15:0] creep_speed;
  logic [31:0] home_shift_distance;
  logic [15:0] homing_accel_time;
  logic [31:0] home_position_data;
  logic [31:0] after_dog_travel;
  logic [7:0]  input_filter_time;
  localparam int unsigned TICK_W_L = hm_pkg::TICK_W;
  logic [TICK_W_L-1:0] tick_cnt_q;
  logic        tick_q;
  logic        sw_start_q;
  logic        sw_abort_q;
  logic [hm_pkg::IN_W-1:0] raw_in;
  logic [hm_pkg::IN_W-1:0] filt;
  logic        dog_act;
  logic        dog_act_q;
  logic        prog_q;
  logic        dog_rise;
  logic        start;
  logic        mode_ok;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] rd_data;
  logic [15:0] speed;
  logic [15:0] target_q;
  logic [31:0] pos_q;
  logic [31:0] mark_q;
  logic [31:0] dist_q;
  logic        cradle_q;
  logic [3:0]  method;
  hm_pkg::hm_state_t state_q;

  if (TICK_CYC < 2 || TICK_CYC >= (1 << TICK_W_L)) begin : g_chk
    $error("hm_dog_homing_seq: TICK_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Motion time base: one-cycle tick every TICK_CYC clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_W_L'(TICK_CYC - 1));
      if (tick_cnt_q == TICK_W_L'(TICK_CYC - 1)) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + TICK_W_L'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input filter and ramp
  assign raw_in = {homing_program_command, table_select_bit2,
                   table_select_bit1, table_select_bit0,
                   auto_manual_select, dog_in};

  hm_in_filter #(.W(hm_pkg::IN_W), .FW(8)) u_filter (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick_q),
    .ftime    (input_filter_time),
    .raw      (raw_in),
    .stable_q (filt)
  );

  hm_ramp #(.SW(16)) u_ramp (
    .pclk        (pclk),
    .presetn     (presetn),
    .tick        (tick_q),
    .target      (target_q),
    .accel_ticks (homing_accel_time),
    .speed_q     (speed)
  );

  assign speed_cmd = speed;

  ////////////////////////////////////////////////////////////////////////
  // APB: no wait states; read data latched in the setup cycle
  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      hm_pkg::A_CTRL:     rd_data = 32'h0000_0000;
      hm_pkg::A_STATUS:   rd_data = {29'h0, home_error, homing_done,
                                     homing_busy};
      hm_pkg::A_METHOD:   rd_data = {16'h0000, homing_method_config};
      hm_pkg::A_HSPEED:   rd_data = {16'h0000, homing_speed};
      hm_pkg::A_CSPEED:   rd_data = {16'h0000, creep_speed};
      hm_pkg::A_SHIFT:    rd_data = home_shift_distance;
      hm_pkg::A_ACCEL:    rd_data = {16'h0000, homing_accel_time};
      hm_pkg::A_HOMEDATA: rd_data = home_position_data;
      hm_pkg::A_AFTERDOG: rd_data = after_dog_travel;
      hm_pkg::A_FILTER:   rd_data = {24'h000000, input_filter_time};
      hm_pkg::A_POSITION: rd_data = pos_q;
      hm_pkg::A_INPUTS:   rd_data = {26'h0, filt};
      default:            addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata  <= rd_data;
        pslverr <= ~addr_ok;
      end
    end
  end

  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // Configuration registers; start and abort are self-clearing pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      homing_method_config <= hm_pkg::RST_METHOD;
      homing_speed         <= hm_pkg::RST_HSPEED;
      creep_speed          <= hm_pkg::RST_CSPEED;
      home_shift_distance  <= 32'h0000_0000;
      homing_accel_time    <= hm_pkg::RST_ACCEL;
      home_position_data   <= 32'h0000_0000;
      after_dog_travel     <= 32'h0000_0000;
      input_filter_time    <= hm_pkg::RST_FILTER;
      sw_start_q           <= 1'b0;
      sw_abort_q           <= 1'b0;
    end else begin
      sw_start_q <= wr_en && paddr == hm_pkg::A_CTRL &&
                    pwdata[hm_pkg::CTRL_START];
      sw_abort_q <= wr_en && paddr == hm_pkg::A_CTRL &&
                    pwdata[hm_pkg::CTRL_ABORT];
      if (wr_en) begin
        case (paddr)
          hm_pkg::A_METHOD:   homing_method_config <= pwdata[15:0];
          hm_pkg::A_HSPEED:   homing_speed         <= pwdata[15:0];
          hm_pkg::A_CSPEED:   creep_speed          <= pwdata[15:0];
          hm_pkg::A_SHIFT:    home_shift_distance  <= pwdata;
          hm_pkg::A_ACCEL:    homing_accel_time    <= pwdata[15:0];
          hm_pkg::A_HOMEDATA: home_position_data   <= pwdata;
          hm_pkg::A_AFTERDOG: after_dog_travel     <= pwdata;
          hm_pkg::A_FILTER:   input_filter_time    <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start conditions and dog front end
  // manual homing mode selected
  assign mode_ok = filt[hm_pkg::IN_AUTO] &&
                   filt[hm_pkg::IN_TS0 +: 3] == 3'b000;
  assign dog_act = homing_method_config[hm_pkg::MC_POL] ?
                   filt[hm_pkg::IN_DOG] : ~filt[hm_pkg::IN_DOG];
  assign method  = homing_method_config[3:0];
  // dog sampled once per clock after filtering
  assign dog_rise = dog_act & ~dog_act_q;
  assign start = mode_ok & ((filt[hm_pkg::IN_PROG] & ~prog_q) | sw_start_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_act_q <= 1'b0;
      prog_q    <= 1'b0;
    end else begin
      dog_act_q <= dog_act;
      prog_q    <= filt[hm_pkg::IN_PROG];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Homing sequencer and position counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= hm_pkg::HM_IDLE;
      pos_q       <= 32'h0000_0000;
      mark_q      <= 32'h0000_0000;
      dist_q      <= 32'h0000_0000;
      target_q    <= 16'h0000;
      cradle_q    <= 1'b0;
      move_dir    <= 1'b0;
      homing_busy <= 1'b0;
      homing_done <= 1'b0;
      home_error  <= 1'b0;
    end else begin
      if (tick_q) begin
        pos_q <= move_dir ? pos_q + {16'h0000, speed}
                          : pos_q - {16'h0000, speed};
      end
      if (sw_abort_q && homing_busy) begin
        target_q    <= 16'h0000;
        homing_busy <= 1'b0;
        home_error  <= 1'b1;
        state_q     <= hm_pkg::HM_IDLE;
      end else begin
        case (state_q)
          hm_pkg::HM_IDLE: begin
            if (start) begin
              homing_done <= 1'b0;
              // count type / cradle type selection
              if (method == hm_pkg::METHOD_COUNT ||
                  method == hm_pkg::METHOD_CRADLE) begin
                cradle_q    <= (method == hm_pkg::METHOD_CRADLE);
                move_dir    <= homing_method_config[hm_pkg::MC_DIR];
                target_q    <= homing_speed;
                homing_busy <= 1'b1;
                home_error  <= 1'b0;
                state_q     <= hm_pkg::HM_FAST;
              end else begin
                home_error <= 1'b1;
              end
            end
          end
          hm_pkg::HM_FAST: begin
            if (dog_rise) begin
              // decelerate to creep at front end
              target_q <= creep_speed;
              mark_q   <= pos_q;
              dist_q   <= after_dog_travel + home_shift_distance;
              // home position follows the speed at this sample
              state_q  <= cradle_q ? hm_pkg::HM_ZWAIT : hm_pkg::HM_COUNT;
            end
          end
          hm_pkg::HM_COUNT: begin
            if (hm_pkg::hm_dist(pos_q, mark_q, move_dir) >= dist_q) begin
              target_q <= 16'h0000;
              state_q  <= hm_pkg::HM_STOP;
            end
          end
          hm_pkg::HM_ZWAIT: begin
            if (index_pulse) begin
              mark_q  <= pos_q;
              dist_q  <= home_shift_distance;
              state_q <= hm_pkg::HM_SHIFT;
            end
          end
          hm_pkg::HM_SHIFT: begin
            if (hm_pkg::hm_dist(pos_q, mark_q, move_dir) >= dist_q) begin
              target_q <= 16'h0000;
              state_q  <= hm_pkg::HM_STOP;
            end
          end
          hm_pkg::HM_STOP: begin
            if (speed == 16'h0000) begin
              state_q <= hm_pkg::HM_LOAD;
            end
          end
          hm_pkg::HM_LOAD: begin
            pos_q   <= home_position_data;
            state_q <= hm_pkg::HM_DONE;
          end
          hm_pkg::HM_DONE: begin
            homing_done <= 1'b1;
            homing_busy <= 1'b0;
            state_q     <= hm_pkg::HM_IDLE;
          end
          default: state_q <= hm_pkg::HM_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fast_dog;
    state_q == hm_pkg::HM_FAST && dog_rise && !sw_abort_q;
  endsequence
  sequence s_zwait_index;
    state_q == hm_pkg::HM_ZWAIT && index_pulse && !sw_abort_q;
  endsequence
  sequence s_idle_start;
    state_q == hm_pkg::HM_IDLE && start && !sw_abort_q;
  endsequence

  cnt_select_a: assert property (s_idle_start ##0
    method == hm_pkg::METHOD_COUNT |=>
    state_q == hm_pkg::HM_FAST && !cradle_q)
    else $error("method 6 did not start count homing");
  cradle_select_a: assert property (s_idle_start ##0
    method == hm_pkg::METHOD_CRADLE |=>
    state_q == hm_pkg::HM_FAST && cradle_q)
    else $error("method 7 did not start cradle homing");
  creep_switch_a: assert property (s_fast_dog |=>
    target_q == $past(creep_speed) && mark_q == $past(pos_q))
    else $error("creep speed or dog mark not taken at front end");
  count_dist_a: assert property (s_fast_dog ##0 !cradle_q |=>
    state_q == hm_pkg::HM_COUNT &&
    dist_q == $past(after_dog_travel) + $past(home_shift_distance))
    else $error("count distance not travel plus shift");
  no_index_a: assert property (state_q == hm_pkg::HM_COUNT &&
    index_pulse |=> state_q != hm_pkg::HM_SHIFT && $stable(dist_q))
    else $error("count homing reacted to the index pulse");
  index_mark_a: assert property (s_zwait_index |=>
    state_q == hm_pkg::HM_SHIFT && mark_q == $past(pos_q) &&
    dist_q == $past(home_shift_distance))
    else $error("index pulse not taken as reference");
  mark_hold_a: assert property (state_q == hm_pkg::HM_COUNT &&
    !sw_abort_q |=> $stable(mark_q))
    else $error("front end mark moved during count");
  dir_hold_a: assert property (homing_busy &&
    state_q != hm_pkg::HM_IDLE |=> $stable(move_dir))
    else $error("direction changed during homing");
  load_home_a: assert property (state_q == hm_pkg::HM_LOAD &&
    !sw_abort_q |=> pos_q == $past(home_position_data) ##1 homing_done)
    else $error("home data not loaded before done");
  done_still_a: assert property ($rose(homing_done) |->
    speed == 16'h0000 && $past(state_q) == hm_pkg::HM_DONE &&
    $past(state_q, 2) == hm_pkg::HM_LOAD)
    else $error("done raised while moving or before load");
endmodule : hm_dog_homing_seq
`default_nettype wire

// File: logic/hm_guard_unused.sv
// Holds no logic; the sequencer lives in the other design files

// File: bench/hm_axis_model.sv
// Axis and encoder model: integrates speed, makes dog and index signals
`timescale 1ns/10ps
`default_nettype none
module hm_axis_model #(
  parameter int unsigned TICK_CYC = 4
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Motion command
  input  wire logic [15:0] speed_cmd,
  input  wire logic        move_dir,
  // Sensors
  output logic             dog_in,
  output logic             index_pulse
);
  logic [31:0] pos_q;
  logic [7:0]  cnt_q;
  logic        z_q;
  // Position moves by the commanded speed once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      pos_q <= 32'h0;
    end else if (cnt_q == 8'(TICK_CYC - 1)) begin
      cnt_q <= 8'h00;
      pos_q <= move_dir ? pos_q + speed_cmd : pos_q - speed_cmd;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Index fires once per 128 pulses, on any crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_q <= 1'b0;
    end else begin
      z_q <= pos_q[7];
    end
  end
  assign index_pulse = pos_q[7] ^ z_q;
  // Dog occupies a fixed stretch of travel, active high
  assign dog_in = (pos_q >= 32'h3E8) && (pos_q < 32'h514);
endmodule : hm_axis_model
`default_nettype wire

// File: bench/hm_dog_homing_seq_test.sv
// Register-level testbench of the homing sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
  err_total++; $display("unexpected at %0t: %s", $time, m); end end
module hm_dog_homing_seq_test;
  localparam int unsigned TC = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic auto_manual_select, homing_program_command, dog_in, index_pulse;
  logic table_select_bit0, table_select_bit1, table_select_bit2;
  logic [15:0] speed_cmd;
  logic move_dir, homing_busy, homing_done, home_error;
  int err_total, cmp_count, tmo;
  hm_dog_homing_seq #(.TICK_CYC(TC)) hm_dog_homing_seq_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .auto_manual_select, .table_select_bit0, .table_select_bit1,
    .table_select_bit2, .homing_program_command, .dog_in, .index_pulse,
    .speed_cmd, .move_dir, .homing_busy, .homing_done, .home_error);
  hm_axis_model #(.TICK_CYC(TC)) hm_axis_model_inst (.pclk, .presetn,
    .speed_cmd, .move_dir, .dog_in, .index_pulse);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard; a full run needs well under this
  always @(posedge pclk) begin
    tmo++;
    if (tmo == 60000) begin
      err_total++;
      finish_test();
    end
  end
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e, m)
  endtask : chk
  task automatic home_wait();
    while (homing_busy !== 1'b1) @(posedge pclk);
    while (homing_done !== 1'b1) @(posedge pclk);
  endtask : home_wait
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {auto_manual_select, homing_program_command} = 2'h0;
    {table_select_bit0, table_select_bit1, table_select_bit2} = 3'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(hm_pkg::A_STATUS, 32'h0, "status reset");
    chk(hm_pkg::A_METHOD, {16'h0, hm_pkg::RST_METHOD}, "method reset");
    chk(hm_pkg::A_HSPEED, {16'h0, hm_pkg::RST_HSPEED}, "speed reset");
    chk(hm_pkg::A_CSPEED, {16'h0, hm_pkg::RST_CSPEED}, "creep reset");
    chk(hm_pkg::A_FILTER, {24'h0, hm_pkg::RST_FILTER}, "filter reset");
    apb(1'b0, 8'h80, 32'h0);
    `CHK(pslverr, 1'b1, "unmapped no error")
    // Operator selects manual homing, table selects off
    // controller setup
    auto_manual_select <= 1'b1;
    chk(hm_pkg::A_INPUTS, 32'h0, "input seen early");
    repeat (20 * TC) @(posedge pclk);
    chk(hm_pkg::A_INPUTS, 32'h2, "input not seen");
    $display("test reset and filter done");
    apb(1'b1, hm_pkg::A_FILTER, 32'h0);
    apb(1'b1, hm_pkg::A_HSPEED, 32'h14);
    apb(1'b1, hm_pkg::A_CSPEED, 32'h5);
    apb(1'b1, hm_pkg::A_AFTERDOG, 32'h190);
    apb(1'b1, hm_pkg::A_SHIFT, 32'hC8);
    apb(1'b1, hm_pkg::A_HOMEDATA, 32'h1234);
    apb(1'b1, hm_pkg::A_POSITION, 32'h5555);
    chk(hm_pkg::A_POSITION, 32'h0, "position written");
    apb(1'b1, hm_pkg::A_METHOD, 32'h105);
    apb(1'b1, hm_pkg::A_CTRL, 32'h1);
    chk(hm_pkg::A_STATUS, 32'h4, "bad method run");
    apb(1'b1, hm_pkg::A_METHOD, 32'h116);
    apb(1'b1, hm_pkg::A_CTRL, 32'h1);
    home_wait();
    chk(hm_pkg::A_STATUS, 32'h2, "count status");
    `CHK(speed_cmd, 16'h0, "moving at done")
    chk(hm_pkg::A_POSITION, 32'h1234, "count home load");
    `CHK(hm_axis_model_inst.pos_q >= 32'h640, 1'b1, "short travel")
    `CHK(move_dir, 1'b1, "count direction")
    $display("test count homing done");
    table_select_bit1 <= 1'b1;
    repeat (10 * TC) @(posedge pclk);
    apb(1'b1, hm_pkg::A_CTRL, 32'h1);
    chk(hm_pkg::A_STATUS, 32'h2, "start not refused");
    table_select_bit1 <= 1'b0;
    // table selects settle well before the next start
    repeat (10 * TC) @(posedge pclk);
    apb(1'b1, hm_pkg::A_METHOD, 32'h107);
    apb(1'b1, hm_pkg::A_SHIFT, 32'h40);
    apb(1'b1, hm_pkg::A_HOMEDATA, 32'hABC);
    homing_program_command <= 1'b1;
    home_wait();
    homing_program_command <= 1'b0;
    chk(hm_pkg::A_POSITION, 32'hABC, "cradle home load");
    `CHK(move_dir, 1'b0, "cradle direction")
    `CHK(hm_axis_model_inst.pos_q < 32'h4C0, 1'b1, "no shift")
    $display("test cradle homing done");
    apb(1'b1, hm_pkg::A_METHOD, 32'h116);
    apb(1'b1, hm_pkg::A_CTRL, 32'h1);
    while (homing_busy !== 1'b1) @(posedge pclk);
    apb(1'b1, hm_pkg::A_CTRL, 32'h2);
    while (homing_busy !== 1'b0) @(posedge pclk);
    chk(hm_pkg::A_STATUS, 32'h4, "abort status");
    `CHK(home_error, 1'b1, "abort error pin")
    `CHK(homing_done, 1'b0, "done after abort")
    $display("test abort done");
    finish_test();
  end
endmodule : hm_dog_homing_seq_test
`default_nettype wire
